/* File: hdl/sfc_top.sv */
// Sequence frame control: frame header bits, hold-off, recovered ranges,
// and acknowledgement credit recovery.
// Assumes synchronous frame strobes from the local sequence engine.
//
// Operation
// - First sequence: contexts 0, first set, end on last, initiative on later.
// - Status sequence: exchange context 1, last set, end on final frame.
// - After init, hold off new sequences for one resource timeout.
// - Add a recovered range entry on each abnormal termination while an entry is free.
// - Drop each entry when its resource timeout has elapsed.
// - Block data frames whose qualifier lies inside an active entry.
// - Out-of-order acks: lost credit returns only after error timeout.
// - Ordered acks: one ack returns credit for all counts up to it.
//
//------------------------------------------------------------
// Interface notes
//------------------------------------------------------------
// Sequence engine side
//   i_seq_start is a one-cycle request for a new sequence.
//   It is taken only with no sequence active and the hold-off over.
//   A refused start is dropped silently, with no grant pulse.
//   o_seq_grant pulses one cycle after a taken start.
//   i_seq_lo and i_seq_hi give the qualifier range of the sequence.
//   That range is kept until the sequence ends or is aborted.
//   i_frame_req asks for one frame of the active sequence.
//   i_frame_last marks the frame that closes the sequence.
//   o_frame_send or o_frame_block pulses one cycle after a request made while a sequence is active and without i_abort.
//   o_frame_control_field holds the header of the last sent frame.
//   A blocked frame leaves the header and the credit untouched.
//   i_abort ends the active sequence and records its range.
//
// Recovered ranges
//   Four entries, each with its own ageing counter.
//   An abort with all four entries in use records nothing.
//   A frame whose qualifier lies in any live entry is blocked.
//   Entries age out one resource timeout after they were made.
//
// Hold-off
//   Armed by reset and by a port init seen after the synchroniser.
//   A long init level keeps the hold-off rearmed until it drops.
//   No sequence is granted while the hold-off runs.
//
// Credit
//   Credit starts at CREDIT_RST and drops by one per sent frame.
//   A frame requested with no credit left is blocked.
//   Out-of-order mode: each ack returns one credit.
//   Out-of-order mode: a short credit with no sequence active
//   is restored in full after one error-detect timeout.
//   Ordered mode: an ack returns credit for every outstanding
//   frame whose count is at or below the acknowledged count.
//   The count base is the first frame sent with nothing owed.
//   Credit never climbs above CREDIT_RST, so a late or repeated
//   ack cannot create credit that the far side never gave.
//
// Register port
//   Offset 0x0: control, bit 0 selects ordered acknowledgements.
//   Offset 0x4: status, bit 0 hold-off, bit 1 active,
//               bits 5:2 recovered range entries in use.
//   Offset 0x8: credit, bits 7:0.
//   Other offsets read as zero; writes to them are ignored.
//   Read data stand for one cycle after the read strobe only.
//   The port never inserts wait states.
//
// Limitations
//   Only one sequence is tracked at a time.
//   Sequence counts wrap at 16 bits; ordered mode assumes that
//   no wrap falls between the ack base and the acknowledged count.
//   Timeouts are parameters; short values suit simulation only.
`timescale 1ns/1ps
module sfc_top
    import sfc_pkg::*;
#(
    parameter int RA_CYC = RA_TOV_CYC,
    parameter int ED_CYC = ED_TOV_CYC
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_port_init,
    input  wire logic             i_seq_start,
    input  wire sfc_seq_e         i_seq_kind,
    input  wire logic [QW-1:0]    i_seq_lo,
    input  wire logic [QW-1:0]    i_seq_hi,
    input  wire logic             i_frame_req,
    input  wire logic             i_frame_last,
    input  wire logic [QW-1:0]    i_frame_qual,
    input  wire logic [15:0]      i_frame_frame_sequence_count,
    input  wire logic             i_abort,
    input  wire logic             i_ack_valid,
    input  wire logic [15:0]      i_ack_frame_sequence_count,
    input  wire logic [3:0]       i_addr,
    input  wire logic [31:0]      i_wdata,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic                  o_seq_grant,
    output logic                  o_frame_send,
    output logic                  o_frame_block,
    output logic [23:0]           o_frame_control_field,
    output logic [31:0]           o_rdata
);
    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    typedef struct packed {
        logic [CNT_W-1:0]          hold_cnt;
        logic                      hold;
        logic                      active;
        sfc_seq_e                  kind;
        logic                      not_first_frame;
        logic [NUM_RR-1:0]         rr_vld;
        logic [NUM_RR-1:0][QW-1:0] rr_lo;
        logic [NUM_RR-1:0][QW-1:0] rr_hi;
        logic [NUM_RR-1:0][CNT_W-1:0] rr_cnt;
        logic [QW-1:0]             cur_lo;
        logic [QW-1:0]             cur_hi;
        logic                      ordered_acks;
        logic [15:0]               sent_cnt;
        logic [15:0]               acked_cnt;
        logic [CRED_W-1:0]         credit;
        logic [CNT_W-1:0]          ed_cnt;
        logic                      send;
        logic                      block;
        logic                      grant;
        logic [23:0]               fcf;
        logic [31:0]               rdata;
    } sfc_state_s;

    sfc_state_s st_r;
    sfc_state_s st_nxt;

    // Port init arrives from the link side, synchronise it
    logic init_s1_r;
    logic init_s2_r;
    always_ff @(posedge i_clk) begin
        init_s1_r <= i_port_init;
        init_s2_r <= init_s1_r;
    end

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    always_comb begin
        logic [NUM_RR-1:0] hit;
        logic              placed;
        logic [15:0]       delta;
        st_nxt        = st_r;
        hit           = '0;
        placed        = 1'b0;
        delta         = 16'h0000;
        st_nxt.send   = 1'b0;
        st_nxt.block  = 1'b0;
        st_nxt.grant  = 1'b0;
        st_nxt.rdata  = 32'h0000_0000;

        // Hold-off after port initialisation
        if (init_s2_r) begin
            st_nxt.hold     = 1'b1;
            st_nxt.hold_cnt = CNT_W'(RA_CYC);
        end else if (st_r.hold) begin
            if (st_r.hold_cnt <= CNT_W'(1)) begin
                st_nxt.hold = 1'b0;
            end
            st_nxt.hold_cnt = st_r.hold_cnt - CNT_W'(1);
        end

        // Recovered range ageing
        for (int i = 0; i < NUM_RR; i++) begin
            if (st_r.rr_vld[i]) begin
                if (st_r.rr_cnt[i] <= CNT_W'(1)) begin
                    st_nxt.rr_vld[i] = 1'b0;
                end
                st_nxt.rr_cnt[i] = st_r.rr_cnt[i] - CNT_W'(1);
                if (i_frame_qual >= st_r.rr_lo[i] &&
                    i_frame_qual <= st_r.rr_hi[i]) begin
                    hit[i] = 1'b1;
                end
            end
        end

        // Abnormal termination records the sequence range
        if (i_abort && st_r.active) begin
            st_nxt.active = 1'b0;
            for (int i = 0; i < NUM_RR; i++) begin
                if (!placed && !st_nxt.rr_vld[i]) begin
                    st_nxt.rr_vld[i] = 1'b1;
                    st_nxt.rr_lo[i]  = st_r.cur_lo;
                    st_nxt.rr_hi[i]  = st_r.cur_hi;
                    st_nxt.rr_cnt[i] = CNT_W'(RA_CYC);
                    placed           = 1'b1;
                end
            end
        end

        // Sequence start
        if (i_seq_start && !st_r.active && !st_r.hold && !init_s2_r) begin
            st_nxt.active          = 1'b1;
            st_nxt.grant           = 1'b1;
            st_nxt.kind            = i_seq_kind;
            st_nxt.not_first_frame = 1'b0;
            st_nxt.cur_lo          = i_seq_lo;
            st_nxt.cur_hi          = i_seq_hi;
        end

        // Frame header generation
        if (i_frame_req && st_r.active && !i_abort) begin
            if (|hit || st_r.credit == '0) begin
                st_nxt.block = 1'b1;
            end else begin
                st_nxt.send   = 1'b1;
                st_nxt.credit = st_r.credit - CRED_W'(1);
                st_nxt.sent_cnt = i_frame_frame_sequence_count;
                // Nothing owed: this frame's count is the ack base
                if (st_r.credit == CREDIT_RST) begin
                    st_nxt.acked_cnt = i_frame_frame_sequence_count;
                end
                st_nxt.fcf    = 24'h00_0000;
                st_nxt.fcf[FC_END] = i_frame_last;
                case (st_r.kind)
                    SFC_SEQ_FIRST: begin
                        st_nxt.fcf[FC_FIRST] = 1'b1;
                        st_nxt.fcf[FC_INIT]  = st_r.not_first_frame;
                    end
                    SFC_SEQ_MID: begin
                        st_nxt.fcf[FC_XCHG_CTX] = 1'b1;
                    end
                    SFC_SEQ_LAST: begin
                        st_nxt.fcf[FC_XCHG_CTX] = 1'b1;
                        st_nxt.fcf[FC_LAST]     = 1'b1;
                    end
                    default: begin
                        st_nxt.fcf = 24'h00_0000;
                    end
                endcase
                st_nxt.not_first_frame = 1'b1;
                if (i_frame_last) begin
                    st_nxt.active = 1'b0;
                end
            end
        end

        // Credit recovery from acknowledgements
        if (st_r.ordered_acks) begin
            if (i_ack_valid && i_ack_frame_sequence_count >= st_r.acked_cnt) begin
                delta = i_ack_frame_sequence_count - st_r.acked_cnt + 16'h0001;
                // Never return more than is outstanding
                if (delta > {8'h00, CREDIT_RST - st_nxt.credit}) begin
                    delta = {8'h00, CREDIT_RST - st_nxt.credit};
                end
                st_nxt.credit = st_nxt.credit + delta[CRED_W-1:0];
                st_nxt.acked_cnt = i_ack_frame_sequence_count + 16'h0001;
            end
        end else begin
            if (i_ack_valid && st_nxt.credit != CREDIT_RST) begin
                st_nxt.credit = st_nxt.credit + CRED_W'(1);
                st_nxt.acked_cnt = st_r.acked_cnt + 16'h0001;
            end
            // Outstanding frames left after the error timeout are restored
            if (st_r.credit != CREDIT_RST && !st_r.active) begin
                if (st_r.ed_cnt <= CNT_W'(1)) begin
                    st_nxt.credit = CREDIT_RST;
                    st_nxt.ed_cnt = CNT_W'(ED_CYC);
                end else begin
                    st_nxt.ed_cnt = st_r.ed_cnt - CNT_W'(1);
                end
            end else begin
                st_nxt.ed_cnt = CNT_W'(ED_CYC);
            end
        end

        // Register writes
        if (i_wr && i_addr == REG_CTRL) begin
            st_nxt.ordered_acks = i_wdata[0];
        end

        // Register reads
        if (i_rd) begin
            case (i_addr)
                REG_CTRL:   st_nxt.rdata = {31'h0, st_r.ordered_acks};
                REG_STATUS: st_nxt.rdata = {26'h0, st_r.rr_vld,
                                            st_r.active, st_r.hold};
                REG_CREDIT: st_nxt.rdata = {24'h0, st_r.credit};
                default:    st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_r        <= '0;
            st_r.hold   <= 1'b1;
            st_r.hold_cnt <= CNT_W'(RA_CYC);
            st_r.credit <= CREDIT_RST;
            st_r.ed_cnt <= CNT_W'(ED_CYC);
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign o_seq_grant           = st_r.grant;
    assign o_frame_send          = st_r.send;
    assign o_frame_block         = st_r.block;
    assign o_frame_control_field = st_r.fcf;
    assign o_rdata               = st_r.rdata;
endmodule

/* File: hdl/sfc_pkg.sv */
// Package for the sequence frame control block.
// Assumes a 100 MHz port clock and a plain register port.
package sfc_pkg;
    // Clock and timeouts
    localparam int CLK_PERIOD_NS = 10;
    localparam int RA_TOV_MS     = 10000;   // Resource allocation timeout, ms
    localparam int ED_TOV_MS     = 2000;    // Error detect timeout, ms
    localparam int RA_TOV_CYC    = RA_TOV_MS * 100000;
    localparam int ED_TOV_CYC    = ED_TOV_MS * 100000;

    // Frame control field bit positions
    localparam int FC_XCHG_CTX = 23;
    localparam int FC_SEQ_CTX  = 22;
    localparam int FC_FIRST    = 21;
    localparam int FC_LAST     = 20;
    localparam int FC_END      = 19;
    localparam int FC_INIT     = 18;

    // Sizes
    localparam int NUM_RR  = 4;   // Recovered range entries
    localparam int QW      = 16;  // Qualifier width
    localparam int CNT_W   = 32;
    localparam int CRED_W  = 8;
    localparam logic [CRED_W-1:0] CREDIT_RST = 8'h10;

    // Register offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CREDIT = 4'h8;

    // Sequence kinds
    typedef enum logic [1:0] {
        SFC_SEQ_FIRST = 2'b00,
        SFC_SEQ_MID   = 2'b01,
        SFC_SEQ_LAST  = 2'b10
    } sfc_seq_e;
endpackage

/* File: bench/sfc_monitor.sv */
// Checker for the sequence frame control block, bound to its top ports.
// Assumes short timeout parameters and one port clock.
`timescale 1ns/1ps
module sfc_monitor
    import sfc_pkg::*;
#(parameter int RA_CYC = 20) (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_port_init,
    input wire logic        i_seq_start,
    input wire sfc_seq_e    i_seq_kind,
    input wire logic        i_frame_req,
    input wire logic        i_frame_last,
    input wire logic        i_rd,
    input wire logic        o_seq_grant,
    input wire logic        o_frame_send,
    input wire logic [23:0] o_frame_control_field,
    input wire logic [31:0] o_rdata
);
    sfc_seq_e    kind_r;
    logic [31:0] idle_r;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Kind of granted sequence, cycles since reset or init
    always_ff @(posedge i_clk) begin
        if (o_seq_grant) kind_r <= sfc_seq_e'($past(i_seq_kind));
        idle_r <= (i_reset || i_port_init) ? 32'h0 : idle_r + 32'h1;
    end
    sequence s_send(sfc_seq_e k);
        o_frame_send && kind_r == k;
    endsequence
    first_hdr_a: assert property (s_send(SFC_SEQ_FIRST) |->
        o_frame_control_field[23:20] == 4'h2) else $error("first hdr");
    reply_hdr_a: assert property (s_send(SFC_SEQ_MID) |->
        o_frame_control_field[23:20] == 4'h8 && !o_frame_control_field[18])
        else $error("reply hdr");
    status_hdr_a: assert property (s_send(SFC_SEQ_LAST) |->
        o_frame_control_field[23:20] == 4'h9 && !o_frame_control_field[18])
        else $error("status hdr");
    end_bit_a: assert property (o_frame_send |->
        o_frame_control_field[19] == $past(i_frame_last)) else $error("end");
    hold_off_a: assert property (o_seq_grant |-> idle_r >= RA_CYC)
        else $error("grant in hold-off");
    grant_cause_a: assert property (o_seq_grant |-> $past(i_seq_start))
        else $error("grant without start");
    frame_cause_a: assert property (o_frame_send |-> $past(i_frame_req))
        else $error("send without request");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside read");
endmodule
bind sfc_top sfc_monitor #(.RA_CYC(RA_CYC)) u_mon (.i_clk, .i_reset,
    .i_port_init, .i_seq_start, .i_seq_kind, .i_frame_req, .i_frame_last,
    .i_rd, .o_seq_grant, .o_frame_send, .o_frame_control_field, .o_rdata);

/* File: bench/sfc_far_port.sv */
// Far port model: acknowledges each frame sent while i_drop is low, in count order.
// Assumes frames spaced at least three cycles apart.
`timescale 1ns/1ps
module sfc_far_port (
    input  wire logic        i_clk,
    input  wire logic        i_frame_req,
    input  wire logic [15:0] i_frame_frame_sequence_count,
    input  wire logic        i_frame_send,
    input  wire logic        i_drop,
    input  wire logic        i_slow,
    output logic             o_ack_valid = 1'h0,
    output logic [15:0]      o_ack_frame_sequence_count = 16'h0
);
    logic [15:0] cnt_r  = 16'h0;
    logic [1:0]  pend_r = 2'h0;
    // Ack two or three cycles after send; count toggles while idle
    always_ff @(posedge i_clk) begin
        if (i_frame_req) cnt_r <= i_frame_frame_sequence_count;
        pend_r <= {pend_r[0], i_frame_send & ~i_drop};
        o_ack_valid <= i_slow ? pend_r[1] : pend_r[0];
        o_ack_frame_sequence_count <= (i_slow ? pend_r[1] : pend_r[0]) ? cnt_r
                                                          : ~o_ack_frame_sequence_count;
    end
endmodule

/* File: bench/sfc_top_tb.sv */
// Self-checking bench for the sequence frame control block.
// Assumes short timeouts and the far port model for acknowledgements.
`timescale 1ns/1ps
module sfc_top_tb;
    import sfc_pkg::*;
    localparam int RA = 20;
    localparam int ED = 20;
    logic i_clk = 0, i_reset = 1, i_port_init = 0, i_seq_start = 0;
    logic i_frame_req = 0, i_frame_last = 0, i_abort = 0, i_wr = 0, i_rd = 0;
    logic i_ack_valid, drop = 0, slow = 0, o_seq_grant, o_frame_send;
    logic o_frame_block;
    sfc_seq_e i_seq_kind = SFC_SEQ_FIRST;
    logic [15:0] i_seq_lo = '0, i_seq_hi = '0, i_frame_qual = '0;
    logic [15:0] i_frame_frame_sequence_count = '0, i_ack_frame_sequence_count, lo;
    logic [3:0]  i_addr = '0;
    logic [31:0] i_wdata = '0, o_rdata;
    logic [23:0] o_frame_control_field;
    int err_count = 0, tests_run = 0, cyc = 0;
    sfc_top #(.RA_CYC(RA), .ED_CYC(ED)) dut (.*);
    sfc_far_port far (.i_clk, .i_frame_req, .i_frame_frame_sequence_count,
        .i_frame_send(o_frame_send), .i_drop(drop), .i_slow(slow),
        .o_ack_valid(i_ack_valid), .o_ack_frame_sequence_count(i_ack_frame_sequence_count));
    always #5 i_clk = ~i_clk;
    // Expected header bits 23..18 for a frame
    function automatic logic [5:0] hdr(sfc_seq_e k, int i, logic last);
        case (k)
            SFC_SEQ_FIRST: hdr = {4'h2, last, 1'(i != 0)};
            SFC_SEQ_MID:   hdr = {4'h8, last, 1'h0};
            default:       hdr = {4'h9, last, 1'h0};
        endcase
    endfunction
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_reg(logic [3:0] a, logic [31:0] exp);
        @(posedge i_clk) begin i_addr <= a; i_rd <= 1; end
        @(posedge i_clk) i_rd <= 0;
        #1 chk(o_rdata, exp);
    endtask
    task automatic start(sfc_seq_e k, logic [15:0] l, logic g);
        @(posedge i_clk) begin i_seq_start <= 1; i_seq_kind <= k; end
        i_seq_lo <= l;
        i_seq_hi <= l + 16'h10;
        @(posedge i_clk) i_seq_start <= 0;
        #1 chk(o_seq_grant, g);
    endtask
    task automatic frame(sfc_seq_e k, int i, logic last, logic [15:0] q,
                         logic [1:0] exp);
        @(posedge i_clk) begin i_frame_req <= 1; i_frame_last <= last; end
        i_frame_qual <= q;
        i_frame_frame_sequence_count <= i_frame_frame_sequence_count + 16'h1;
        @(posedge i_clk) i_frame_req <= 0;
        #1 chk({o_frame_send, o_frame_block}, exp);
        if (exp[1]) chk(o_frame_control_field[23:18], hdr(k, i, last));
        @(posedge i_clk);
    endtask
    task automatic run_seq(sfc_seq_e k, int n);
        start(k, 16'hF000, 1);
        for (int i = 0; i < n; i++)
            frame(k, i, i == n - 1, 16'(($urandom & 32'h7FFF)), 2'h2);
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin err_count++; print_verdict(); end
    end
    initial begin
        void'($urandom(32'h6EE9));
        repeat (2) @(posedge i_clk);
        i_reset <= 0;
        rd_reg(REG_STATUS, 32'h1);
        rd_reg(REG_CREDIT, 32'h10);
        rd_reg(4'hC, 32'h0);
        start(SFC_SEQ_FIRST, 16'hF000, 0);
        repeat (RA) @(posedge i_clk);
        for (int k = 0; k < 3; k++) run_seq(sfc_seq_e'(k), 1 + $urandom % 4);
        // Init pulse restarts the hold-off
        @(posedge i_clk) i_port_init <= 1;
        @(posedge i_clk) i_port_init <= 0;
        repeat (4) @(posedge i_clk);
        start(SFC_SEQ_FIRST, 16'hF000, 0);
        repeat (RA + 4) @(posedge i_clk);
        // Abort records a range that blocks frames until it times out
        lo = 16'h8000 + 16'($urandom % 256);
        start(SFC_SEQ_MID, lo, 1);
        @(posedge i_clk) i_abort <= 1;
        @(posedge i_clk) i_abort <= 0;
        rd_reg(REG_STATUS, 32'h4);
        start(SFC_SEQ_MID, 16'hF000, 1);
        frame(SFC_SEQ_MID, 0, 0, lo + 16'h3, 2'h1);
        frame(SFC_SEQ_MID, 1, 1, 16'h0100, 2'h2);
        repeat (RA + 4) @(posedge i_clk);
        rd_reg(REG_STATUS, 32'h0);
        start(SFC_SEQ_MID, 16'hF000, 1);
        frame(SFC_SEQ_MID, 0, 1, lo + 16'h3, 2'h2);
        // Lost ack credit returns only after the error timeout
        drop <= 1;
        run_seq(SFC_SEQ_MID, 1);
        drop <= 0;
        rd_reg(REG_CREDIT, 32'hF);
        repeat (ED + 4) @(posedge i_clk);
        rd_reg(REG_CREDIT, 32'h10);
        // Ordered acks: one slow ack returns all earlier credit
        @(posedge i_clk) begin i_wr <= 1; i_wdata <= 32'h1; end
        i_addr <= REG_CTRL;
        @(posedge i_clk) i_wr <= 0;
        {drop, slow} <= 2'h3;
        start(SFC_SEQ_MID, 16'hF000, 1);
        frame(SFC_SEQ_MID, 0, 0, 16'h0200, 2'h2);
        frame(SFC_SEQ_MID, 1, 0, 16'h0201, 2'h2);
        drop <= 0;
        frame(SFC_SEQ_MID, 2, 1, 16'h0202, 2'h2);
        repeat (4) @(posedge i_clk);
        rd_reg(REG_CREDIT, 32'h10);
        print_verdict();
    end
endmodule
